// file: pkg/eep_map.svh
// Constants for the serial memory link: address fields, sizes and timing
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH
`define EEP_DEV_PREFIX 4'hA
`define EEP_PAGE_BYTES 32
`define EEP_MEM_WORDS 4096
`define EEP_SYS_NS 5
`define EEP_TWR_NS 5000000
`define EEP_TWR_CYC (`EEP_TWR_NS / `EEP_SYS_NS)
`define EEP_PUP_NS 100000
`define EEP_PUP_CYC ((`EEP_PUP_NS + `EEP_SYS_NS - 1) / `EEP_SYS_NS)
`define EEP_QTR_NS 625
`define EEP_QTR_CYC ((`EEP_QTR_NS + `EEP_SYS_NS - 1) / `EEP_SYS_NS)
`define EEP_POLL_MAX 10'h3FF
`endif

// file: pkg/eep_pkg.sv
// State and command types for the device end and the controller end of the serial memory link
package eep_pkg;
  typedef enum logic [1:0] {EEP_OP_WRITE, EEP_OP_CUR_READ, EEP_OP_RAND_READ} eep_op_e;
  typedef enum logic [2:0] {D_IDLE, D_DEV, D_AHI, D_ALO, D_WDAT, D_RDAT} eep_dst_e;
  typedef enum logic [1:0] {W_IDLE, W_COPY, W_WAIT} eep_wst_e;
  typedef enum logic [2:0] {H_PUP, H_IDLE, H_START, H_BIT, H_STOP} eep_hst_e;
  typedef enum logic [2:0] {J_DEV, J_AHI, J_ALO, J_WR, J_RDEV, J_RD, J_POLL} eep_job_e;
endpackage : eep_pkg

// file: pkg/eep_link_if.sv
// Two-wire link between controller and memory device, with wired-AND data line
`timescale 1ns/1ps
interface eep_link_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  assign sda = ((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o)) ? 1'b0 : 1'b1;
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (output scl, input sda, output ctl_sda_o, output ctl_sda_oe);
endinterface : eep_link_if

// file: hw/eep_mem_dev.sv
// Serial memory device end: bit engine, address counter, page buffer, write timer
`timescale 1ns/1ps
`include "eep_map.svh"
module eep_mem_dev import eep_pkg::*; #(
  parameter int WR_CYC = `EEP_TWR_CYC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Chip select straps
  input wire logic [2:0] chip_select_pins,
  // High in reset and while a self-timed write is in progress
  output logic write_busy,
  // Serial link
  eep_link_if.dev lnk
);
  localparam logic [19:0] WR_LAST = 20'(WR_CYC - 1);

  // Memory array and page buffer
  logic [7:0] mem_q [`EEP_MEM_WORDS];
  logic [7:0] buf_q [`EEP_PAGE_BYTES];

  // Link side
  eep_dst_e dst_q, dst_d;
  logic [3:0] cnt_q, cnt_d;
  logic [6:0] sh_q, sh_d;
  logic [11:0] ptr_q, ptr_d;
  logic [11:0] ctr_q, ctr_d;
  logic [7:0] ob_q, ob_d;
  logic [7:0] byte_in, rd_byte;
  logic oe_pos_q, oe_pos_d, oe_q;
  logic pend_q, pend_d, buf_we;
  logic [31:0] mask_q, mask_d;
  logic start_tgl_q, start_seen_q, stop_tgl_q;
  logic start_pend, match;
  logic blk_s1_q, blk_s2_q;
  logic [2:0] cs_s1_q, cs_s2_q;

  // System side
  eep_wst_e wst_q, wst_d;
  logic [4:0] idx_q, idx_d;
  logic [19:0] tmr_q, tmr_d;
  logic block_q, block_d, mem_we;
  logic stop_s1_q, stop_s2_q, stop_s3_q, stop_evt;
  logic pend_s1_q, pend_s2_q;

  // START: data falls while clock high
  always_ff @(negedge lnk.sda or posedge srst) begin
    if (srst) begin
      start_tgl_q <= 1'b0;
    end else if (lnk.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // STOP: data rises while clock high
  always_ff @(posedge lnk.sda or posedge srst) begin
    if (srst) begin
      stop_tgl_q <= 1'b0;
    end else if (lnk.scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  assign start_pend = start_tgl_q ^ start_seen_q;
  assign byte_in = {sh_q, lnk.sda};
  assign rd_byte = mem_q[ctr_q];
  assign match = (byte_in[7:4] == `EEP_DEV_PREFIX) && (byte_in[3:1] == cs_s2_q);

  // Bit engine, sampled on rising clock
  always_comb begin
    dst_d = dst_q;
    cnt_d = cnt_q + 4'h1;
    sh_d = byte_in[6:0];
    ptr_d = ptr_q;
    ctr_d = ctr_q;
    ob_d = {ob_q[6:0], 1'b1};
    oe_pos_d = 1'b0;
    pend_d = pend_q;
    mask_d = mask_q;
    buf_we = 1'b0;
    if (start_pend) begin
      dst_d = D_DEV;
      cnt_d = 4'h1;
      pend_d = 1'b0;
      mask_d = 32'h0000_0000;
    end else if (dst_q == D_IDLE) begin
      cnt_d = cnt_q;
    end else if (cnt_q == 4'h8) begin
      cnt_d = 4'h0;
      if (dst_q == D_RDAT) begin
        if (lnk.sda) begin
          dst_d = D_IDLE;
        end else begin
          ob_d = rd_byte;
          oe_pos_d = ~rd_byte[7];
          ctr_d = ctr_q + 12'h001;
        end
      end
    end else if (cnt_q == 4'h7) begin
      unique case (dst_q)
        D_DEV: begin
          if (match && !blk_s2_q) begin
            oe_pos_d = 1'b1;
            dst_d = byte_in[0] ? D_RDAT : D_AHI;
          end else begin
            dst_d = D_IDLE;
          end
        end
        D_AHI: begin
          ptr_d[11:8] = byte_in[3:0];
          oe_pos_d = 1'b1;
          dst_d = D_ALO;
        end
        D_ALO: begin
          ptr_d[7:0] = byte_in;
          ctr_d = {ptr_q[11:8], byte_in};
          oe_pos_d = 1'b1;
          dst_d = D_WDAT;
        end
        D_WDAT: begin
          buf_we = 1'b1;
          mask_d[ptr_q[4:0]] = 1'b1;
          ptr_d[4:0] = ptr_q[4:0] + 5'h01;
          ctr_d = {ptr_q[11:5], ptr_q[4:0] + 5'h01};
          pend_d = 1'b1;
          oe_pos_d = 1'b1;
        end
        D_RDAT: begin
          oe_pos_d = 1'b0;
        end
        D_IDLE: begin
          dst_d = D_IDLE;
        end
      endcase
    end else if (dst_q == D_RDAT) begin
      oe_pos_d = ~ob_q[6];
    end
  end

  always_ff @(posedge lnk.scl or posedge srst) begin
    if (srst) begin
      dst_q <= D_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 7'h00;
      ptr_q <= 12'h000;
      ctr_q <= 12'h000;
      ob_q <= 8'hFF;
      oe_pos_q <= 1'b0;
      pend_q <= 1'b0;
      mask_q <= 32'h0000_0000;
      start_seen_q <= 1'b0;
      blk_s1_q <= 1'b1;
      blk_s2_q <= 1'b1;
      cs_s1_q <= 3'h0;
      cs_s2_q <= 3'h0;
    end else begin
      dst_q <= dst_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ctr_q <= ctr_d;
      ob_q <= ob_d;
      oe_pos_q <= oe_pos_d;
      pend_q <= pend_d;
      mask_q <= mask_d;
      start_seen_q <= start_tgl_q;
      blk_s1_q <= block_q;
      blk_s2_q <= blk_s1_q;
      cs_s1_q <= chip_select_pins;
      cs_s2_q <= cs_s1_q;
    end
  end

  // Page buffer written as each data byte completes
  always_ff @(posedge lnk.scl) begin
    if (buf_we) begin
      buf_q[ptr_q[4:0]] <= byte_in;
    end
  end

  // Data line changes only while clock is low
  always_ff @(negedge lnk.scl or posedge srst) begin
    if (srst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_pos_q;
    end
  end

  assign lnk.dev_sda_oe = oe_q;
  assign lnk.dev_sda_o = 1'b0;

  // Self-timed programming after STOP
  assign stop_evt = stop_s2_q ^ stop_s3_q;

  always_comb begin
    wst_d = wst_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    mem_we = 1'b0;
    unique case (wst_q)
      W_IDLE: begin
        if (stop_evt && pend_s2_q) begin
          wst_d = W_COPY;
          idx_d = 5'h00;
        end
      end
      W_COPY: begin
        mem_we = mask_q[idx_q];
        idx_d = idx_q + 5'h01;
        if (idx_q == 5'h1F) begin
          wst_d = W_WAIT;
          tmr_d = 20'h00000;
        end
      end
      W_WAIT: begin
        tmr_d = tmr_q + 20'h00001;
        if (tmr_q == WR_LAST) begin
          wst_d = W_IDLE;
        end
      end
    endcase
    block_d = (wst_d != W_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wst_q <= W_IDLE;
      idx_q <= 5'h00;
      tmr_q <= 20'h00000;
      block_q <= 1'b1;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      stop_s3_q <= 1'b0;
      pend_s1_q <= 1'b0;
      pend_s2_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      block_q <= block_d;
      stop_s1_q <= stop_tgl_q;
      stop_s2_q <= stop_s1_q;
      stop_s3_q <= stop_s2_q;
      pend_s1_q <= pend_q;
      pend_s2_q <= pend_s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem_q[{ptr_q[11:5], idx_q}] <= buf_q[idx_q];
    end
  end

  assign write_busy = block_q;

endmodule : eep_mem_dev

// file: hw/eep_bus_ctl.sv
// Bus controller end: clock divider, START/STOP, byte transfers, acknowledge polling
`timescale 1ns/1ps
`include "eep_map.svh"
module eep_bus_ctl import eep_pkg::*; #(
  parameter int PUP_CYC = `EEP_PUP_CYC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Command
  input wire logic cmd_valid,
  input wire eep_op_e cmd_op,
  input wire logic [2:0] cmd_sel,
  input wire logic [11:0] cmd_addr,
  input wire logic [4:0] cmd_count_m1,
  output logic cmd_ready,
  // Write data
  input wire logic [7:0] wr_data,
  output logic wr_take,
  // Read data
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Completion
  output logic done,
  output logic done_err,
  // Serial link
  eep_link_if.ctl lnk
);
  localparam logic [14:0] PUP_LAST = 15'(PUP_CYC - 1);
  localparam logic [7:0] QTR_LAST = 8'(`EEP_QTR_CYC - 1);

  eep_hst_e st_q, st_d;
  eep_job_e job_q, job_d;
  eep_op_e op_q, op_d;
  logic [14:0] pup_q, pup_d;
  logic [7:0] qc_q, qc_d, txb_q, txb_d, rx_q, rx_d, rdat_q, rdat_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [4:0] left_q, left_d;
  logic [11:0] addr_q, addr_d;
  logic [2:0] sel_q, sel_d;
  logic [9:0] retry_q, retry_d;
  logic scl_q, scl_d, oe_q, oe_d, ack_q, ack_d, poll_q, poll_d, err_q, err_d;
  logic rdy_q, rdy_d, take_q, take_d, rdv_q, rdv_d, done_q, done_d, derr_q, derr_d;
  logic sda_s1_q, sda_s2_q, tick, drv, acked;
  logic [7:0] dev_w, dev_r;

  assign tick = (qc_q == QTR_LAST);
  assign acked = ~ack_q;
  assign dev_w = {`EEP_DEV_PREFIX, sel_q, 1'b0};
  assign dev_r = {`EEP_DEV_PREFIX, sel_q, 1'b1};
  assign drv = (bit_q == 4'h8) ? ((job_q == J_RD) && (left_q != 5'h00))
                               : ((job_q != J_RD) && ~txb_q[7]);

  always_comb begin
    st_d = st_q;
    job_d = job_q;
    op_d = op_q;
    pup_d = pup_q;
    qc_d = 8'h00;
    ph_d = ph_q;
    bit_d = bit_q;
    txb_d = txb_q;
    rx_d = rx_q;
    rdat_d = rdat_q;
    left_d = left_q;
    addr_d = addr_q;
    sel_d = sel_q;
    retry_d = retry_q;
    scl_d = scl_q;
    oe_d = oe_q;
    ack_d = ack_q;
    poll_d = poll_q;
    err_d = err_q;
    take_d = 1'b0;
    rdv_d = 1'b0;
    done_d = 1'b0;
    derr_d = derr_q;
    unique case (st_q)
      H_PUP: begin
        pup_d = pup_q + 15'h0001;
        if (pup_q == PUP_LAST) begin
          st_d = H_IDLE;
        end
      end
      H_IDLE: begin
        if (cmd_valid) begin
          op_d = cmd_op;
          sel_d = cmd_sel;
          addr_d = cmd_addr;
          left_d = cmd_count_m1;
          job_d = (cmd_op == EEP_OP_CUR_READ) ? J_RDEV : J_DEV;
          txb_d = {`EEP_DEV_PREFIX, cmd_sel, cmd_op == EEP_OP_CUR_READ};
          err_d = 1'b0;
          retry_d = 10'h000;
          ph_d = 2'h0;
          st_d = H_START;
        end
      end
      H_START, H_STOP, H_BIT: begin
        qc_d = tick ? 8'h00 : qc_q + 8'h01;
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (st_q == H_START) begin
            unique case (ph_q)
              2'h0: oe_d = 1'b0;
              2'h1: scl_d = 1'b1;
              2'h2: oe_d = 1'b1;
              2'h3: begin
                scl_d = 1'b0;
                bit_d = 4'h0;
                st_d = H_BIT;
              end
            endcase
          end else if (st_q == H_STOP) begin
            unique case (ph_q)
              2'h0: oe_d = 1'b1;
              2'h1: scl_d = 1'b1;
              2'h2: oe_d = 1'b0;
              2'h3: begin
                if (poll_q) begin
                  job_d = J_POLL;
                  txb_d = dev_w;
                  st_d = H_START;
                end else begin
                  done_d = 1'b1;
                  derr_d = err_q;
                  st_d = H_IDLE;
                end
              end
            endcase
          end else begin
            unique case (ph_q)
              2'h0: oe_d = drv;
              2'h1: scl_d = 1'b1;
              2'h2: begin
                if (bit_q == 4'h8) begin
                  ack_d = sda_s2_q;
                end else begin
                  rx_d = {rx_q[6:0], sda_s2_q};
                  txb_d = {txb_q[6:0], 1'b1};
                end
              end
              2'h3: begin
                scl_d = 1'b0;
                bit_d = bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  bit_d = 4'h0;
                  unique case (job_q)
                    J_DEV: begin
                      if (acked) begin
                        job_d = J_AHI;
                        txb_d = {4'h0, addr_q[11:8]};
                      end else begin
                        err_d = 1'b1;
                        st_d = H_STOP;
                      end
                    end
                    J_AHI: begin
                      job_d = J_ALO;
                      txb_d = addr_q[7:0];
                    end
                    J_ALO: begin
                      if (op_q == EEP_OP_WRITE) begin
                        job_d = J_WR;
                        txb_d = wr_data;
                        take_d = 1'b1;
                      end else begin
                        job_d = J_RDEV;
                        txb_d = dev_r;
                        st_d = H_START;
                      end
                    end
                    J_WR: begin
                      if (left_q != 5'h00) begin
                        left_d = left_q - 5'h01;
                        txb_d = wr_data;
                        take_d = 1'b1;
                      end else begin
                        poll_d = 1'b1;
                        st_d = H_STOP;
                      end
                    end
                    J_RDEV: begin
                      if (acked) begin
                        job_d = J_RD;
                      end else begin
                        err_d = 1'b1;
                        st_d = H_STOP;
                      end
                    end
                    J_RD: begin
                      rdat_d = rx_q;
                      rdv_d = 1'b1;
                      if (left_q != 5'h00) begin
                        left_d = left_q - 5'h01;
                      end else begin
                        st_d = H_STOP;
                      end
                    end
                    J_POLL: begin
                      st_d = H_STOP;
                      if (acked) begin
                        poll_d = 1'b0;
                      end else if (retry_q == `EEP_POLL_MAX) begin
                        poll_d = 1'b0;
                        err_d = 1'b1;
                      end else begin
                        retry_d = retry_q + 10'h001;
                      end
                    end
                  endcase
                end
              end
            endcase
          end
        end
      end
    endcase
    rdy_d = (st_d == H_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= H_PUP;
      job_q <= J_DEV;
      op_q <= EEP_OP_WRITE;
      pup_q <= 15'h0000;
      qc_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      txb_q <= 8'hFF;
      rx_q <= 8'h00;
      rdat_q <= 8'h00;
      left_q <= 5'h00;
      addr_q <= 12'h000;
      sel_q <= 3'h0;
      retry_q <= 10'h000;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      ack_q <= 1'b1;
      poll_q <= 1'b0;
      err_q <= 1'b0;
      rdy_q <= 1'b0;
      take_q <= 1'b0;
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      derr_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      st_q <= st_d;
      job_q <= job_d;
      op_q <= op_d;
      pup_q <= pup_d;
      qc_q <= qc_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      txb_q <= txb_d;
      rx_q <= rx_d;
      rdat_q <= rdat_d;
      left_q <= left_d;
      addr_q <= addr_d;
      sel_q <= sel_d;
      retry_q <= retry_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      ack_q <= ack_d;
      poll_q <= poll_d;
      err_q <= err_d;
      rdy_q <= rdy_d;
      take_q <= take_d;
      rdv_q <= rdv_d;
      done_q <= done_d;
      derr_q <= derr_d;
      sda_s1_q <= lnk.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign lnk.scl = scl_q;
  assign lnk.ctl_sda_oe = oe_q;
  assign lnk.ctl_sda_o = 1'b0;
  assign cmd_ready = rdy_q;
  assign wr_take = take_q;
  assign rd_data = rdat_q;
  assign rd_valid = rdv_q;
  assign done = done_q;
  assign done_err = derr_q;

endmodule : eep_bus_ctl

// file: testbench/eep_link_assertions.sv
// Checker for the two-wire link between controller and memory device
`timescale 1ns/1ps
module eep_link_assertions #(
  parameter int WR_CYC = 6000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // Device side
  input wire logic [2:0] chip_select_pins,
  input wire logic write_busy
);
  localparam int BUSY_MAX = WR_CYC + 64;
  logic scl_q, sda_q, ack_q, ack_d, busy_f_q, busy_f_d;
  logic [4:0] bits_q, bits_d;
  logic [7:0] dbyte_q, dbyte_d;
  logic [31:0] bcnt_q, bcnt_d;
  logic start_w, stop_w, rise_w;
  always_comb begin
    start_w = scl && scl_q && sda_q && !sda;
    stop_w = scl && scl_q && !sda_q && sda;
    rise_w = scl && !scl_q;
    bits_d = bits_q;
    dbyte_d = dbyte_q;
    ack_d = ack_q;
    busy_f_d = busy_f_q || write_busy;
    bcnt_d = write_busy ? bcnt_q + 32'h1 : 32'h0;
    if (start_w) begin
      bits_d = 5'h00;
      ack_d = 1'b0;
      busy_f_d = write_busy;
    end else if (rise_w && bits_q != 5'h1F) begin
      bits_d = bits_q + 5'h01;
      if (bits_q < 5'h08) dbyte_d = {dbyte_q[6:0], sda};
      if (bits_q == 5'h08) ack_d = !sda;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bits_q <= 5'h1F;
      dbyte_q <= 8'h00;
      ack_q <= 1'b0;
      busy_f_q <= 1'b1;
      bcnt_q <= 32'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      bits_q <= bits_d;
      dbyte_q <= dbyte_d;
      ack_q <= ack_d;
      busy_f_q <= busy_f_d;
      bcnt_q <= bcnt_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  open_drain_a:
    assert property (!dev_sda_o && !ctl_sda_o) else $error("data line driven high");
  busy_silent_a:
    assert property (write_busy |-> !dev_sda_oe) else $error("device drove line while busy");
  reset_quiet_a:
    assert property (disable iff (1'b0) srst && $past(srst) |-> write_busy && !dev_sda_oe
      && !ctl_sda_oe && scl) else $error("link not quiet in reset");
  reset_release_a:
    assert property ($fell(srst) |-> ##[1:3] !write_busy) else $error("busy after reset");
  prefix_match_a:
    assert property (dev_sda_oe && bits_q == 5'h08 |-> dbyte_q[7:1] == {4'hA, chip_select_pins})
      else $error("device acked a foreign address");
  idle_ack_a:
    assert property (bits_q == 5'h09 && scl && !busy_f_q
      && dbyte_q[7:1] == {4'hA, chip_select_pins} |-> !sda) else $error("idle device nacked");
  write_dir_a:
    assert property (ack_q && !dbyte_q[0] && bits_q > 5'h09 && bits_q < 5'h11 |-> !dev_sda_oe)
      else $error("device drove line in write address byte");
  read_dir_a:
    assert property (ack_q && dbyte_q[0] && bits_q > 5'h09 && bits_q < 5'h11 |-> !ctl_sda_oe)
      else $error("controller drove line in read byte");
  shift_low_a:
    assert property ($changed(dev_sda_oe) |-> !scl) else $error("device changed data with clock high");
  busy_bound_a:
    assert property (bcnt_q <= 32'(BUSY_MAX)) else $error("self-timed write too long");
  stop_standby_a:
    assert property (stop_w |-> !dev_sda_oe [*8]) else $error("device active after stop");
endmodule : eep_link_assertions

// file: testbench/test_eeprom_serial_read_poll_logic.sv
// Testbench for both ends of the serial memory link
`timescale 1ns/1ps
module test_eeprom_serial_read_poll_logic import eep_pkg::*;;
  localparam int WR_CYC_T = 6000;
  logic sys_clk = 1'b1;
  logic srst = 1'b0;
  logic cmd_valid = 1'b0;
  eep_op_e cmd_op = EEP_OP_WRITE;
  logic [2:0] cmd_sel = 3'h5;
  logic [11:0] cmd_addr = 12'h000;
  logic [4:0] cmd_count_m1 = 5'h00;
  logic [7:0] wr_data = 8'hA5;
  logic [2:0] chip_select_pins = 3'h5;
  logic cmd_ready, wr_take, rd_valid, done, done_err, write_busy, err_seen;
  logic [7:0] rd_data;
  logic [7:0] wdat [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
  logic [7:0] rq [$];
  int widx = 0;
  int n_errors = 0;
  int check_count = 0;
  eep_link_if lnk_if ();
  always #2.5 sys_clk = ~sys_clk;
  eep_mem_dev #(.WR_CYC(WR_CYC_T)) eep_mem_dev_inst (.sys_clk(sys_clk), .srst(srst),
    .chip_select_pins(chip_select_pins), .write_busy(write_busy), .lnk(lnk_if));
  eep_bus_ctl #(.PUP_CYC(10)) eep_bus_ctl_inst (.sys_clk(sys_clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
    .cmd_count_m1(cmd_count_m1), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .done_err(done_err), .lnk(lnk_if));
  eep_link_assertions #(.WR_CYC(WR_CYC_T)) eep_link_assertions_inst (.sys_clk(sys_clk),
    .srst(srst), .scl(lnk_if.scl), .sda(lnk_if.sda), .ctl_sda_o(lnk_if.ctl_sda_o),
    .ctl_sda_oe(lnk_if.ctl_sda_oe), .dev_sda_o(lnk_if.dev_sda_o),
    .dev_sda_oe(lnk_if.dev_sda_oe), .chip_select_pins(chip_select_pins),
    .write_busy(write_busy));
  always @(posedge sys_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  always @(negedge sys_clk) begin
    if (wr_take === 1'b1) widx = widx + 1;
    wr_data = wdat[widx % 4];
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic run_cmd(input eep_op_e op, input logic [2:0] sel, input logic [11:0] addr,
    input logic [4:0] cm1);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sel = sel;
    cmd_addr = addr;
    cmd_count_m1 = cm1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    err_seen = 1'bx;
    rq.delete();
    for (n = 0; n < 100000; n++) begin
      @(posedge sys_clk);
      if (done === 1'b1) begin
        err_seen = done_err;
        break;
      end
    end
  endtask : run_cmd
  task automatic test_reset();
    check({7'h0, write_busy}, 8'h01);
    check({7'h0, cmd_ready}, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_page_write();
    run_cmd(EEP_OP_WRITE, 3'h5, 12'h03F, 5'h03);
    check({7'h0, err_seen}, 8'h00);
    check(8'(widx), 8'h04);
    $display("test_page_write done");
  endtask : test_page_write
  task automatic test_random_read();
    run_cmd(EEP_OP_RAND_READ, 3'h5, 12'h020, 5'h01);
    check({7'h0, err_seen}, 8'h00);
    check(8'(rq.size()), 8'h02);
    check(rq[0], wdat[1]);
    check(rq[1], wdat[2]);
    $display("test_random_read done");
  endtask : test_random_read
  task automatic test_current_read();
    run_cmd(EEP_OP_CUR_READ, 3'h5, 12'hFFF, 5'h00);
    check({7'h0, err_seen}, 8'h00);
    check(8'(rq.size()), 8'h01);
    check(rq[0], wdat[3]);
    $display("test_current_read done");
  endtask : test_current_read
  task automatic test_bad_select();
    run_cmd(EEP_OP_RAND_READ, 3'h2, 12'h020, 5'h00);
    check({7'h0, err_seen}, 8'h01);
    check(8'(rq.size()), 8'h00);
    $display("test_bad_select done");
  endtask : test_bad_select
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (12) @(negedge sys_clk);
    test_reset();
    srst = 1'b0;
    test_page_write();
    test_random_read();
    test_current_read();
    test_bad_select();
    results();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
endmodule : test_eeprom_serial_read_poll_logic
